// ---- shared/sirq_defs.svh ----
// constants for the serial interrupt, low-power and pin-ownership block
`ifndef SIRQ_DEFS_SVH
`define SIRQ_DEFS_SVH
`define SIRQ_BITS 8
`define SIRQ_CNT_W 3
`define SIRQ_CLK_NS 10
`define SIRQ_HALF_NS 40
`define SIRQ_HALF_CYC (`SIRQ_HALF_NS / `SIRQ_CLK_NS)
`define SIRQ_DIV_W 4
`define SIRQ_TX_RST 1'b1
`define SIRQ_FLAG_RST 1'b0
`define SIRQ_DATA_RST 8'h00
`endif

// ---- shared/sirq_pkg.sv ----
// types shared by the serial interrupt block
package sirq_pkg;
  typedef struct packed {
    logic stat_rd;
    logic data_rd;
    logic data_wr;
    logic ctrl_wr;
    logic [7:0] wdata;
  } sirq_acc_t;
  typedef struct packed {
    logic module_enable;
    logic master_select;
    logic clock_phase;
    logic fault_detect_enable;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic error_irq_enable;
  } sirq_cfg_t;
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } sirq_flags_t;
  typedef enum logic [1:0] {
    SIRQ_M_IDLE = 2'b00,
    SIRQ_M_RUN = 2'b01,
    SIRQ_M_DONE = 2'b11
  } sirq_mst_t;
endpackage

// ---- hdl/sirq_top.sv ----
// serial peripheral: flags, interrupt requests, low-power, break and pin ownership
`timescale 1ns/1ps
`default_nettype none
`include "sirq_defs.svh"
module sirq_top import sirq_pkg::*; (
  // system
  input wire logic mclk,
  input wire logic rstn,
  // processor side
  input wire sirq_cfg_t cfg,
  input wire sirq_acc_t acc,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  output logic [7:0] rx_data_q,
  output sirq_flags_t flags_q,
  output logic irq_tx_q,
  output logic irq_rx_q,
  output logic irq_err_q,
  output logic wake_q,
  // pin ownership
  output logic pins_owned_q,
  output logic ss_gpio_q,
  // link pins
  input wire logic link_sck,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic mosi_o,
  output logic mosi_oe_n_q,
  output logic miso_o,
  output logic miso_oe_n_q,
  output logic sck_o,
  output logic sck_oe_n_q
);
  logic [7:0] tx_hold_q;
  logic [7:0] tx_shadow_q;
  logic [1:0] ss_sync_q;
  logic [1:0] miso_sync_q;
  logic [1:0] tgl_sync_q;
  logic [1:0] busy_sync_q;
  logic ss_prev_q, tgl_prev_q, xfer_open_q;
  logic ss_low;
  logic slave_sel;
  logic protect;
  logic stat_rd, data_rd, data_wr, ctrl_wr;
  logic slave_done;
  logic mst_done;
  logic byte_done;
  logic [7:0] byte_in;
  logic tx_move;
  logic fault_now;
  logic arm_rx_q, arm_ovr_q, arm_mf_q;
  sirq_mst_t mst_q;
  logic [`SIRQ_DIV_W-1:0] div_q;
  logic [`SIRQ_CNT_W-1:0] mbit_q;
  logic [7:0] msh_q;
  logic mcap_q;
  // link-domain state, clocked by the partner's serial clock
  logic link_rst_n;
  logic [`SIRQ_CNT_W-1:0] lcnt_q;
  logic [6:0] lsh_q;
  logic [7:0] lword_q;
  logic ltgl_q;
  logic lbusy_q;

  assign ss_low = ~ss_sync_q[1];
  assign slave_sel = cfg.module_enable & ~cfg.master_select & ss_low;
  assign protect = break_active & ~break_clear_enable;
  // accesses are not reachable while the processor waits
  assign stat_rd = acc.stat_rd & ~wait_mode;
  assign data_rd = acc.data_rd & ~wait_mode;
  assign data_wr = acc.data_wr & ~wait_mode;
  assign ctrl_wr = acc.ctrl_wr & ~wait_mode;

  // two-flop synchronisers for pins and link-domain events
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ss_sync_q <= 2'b11;
      miso_sync_q <= 2'b00;
      tgl_sync_q <= 2'b00;
      busy_sync_q <= 2'b00;
      ss_prev_q <= 1'b1;
      tgl_prev_q <= 1'b0;
      xfer_open_q <= 1'b0;
    end else begin
      ss_sync_q <= {ss_sync_q[0], ss_n_i};
      miso_sync_q <= {miso_sync_q[0], miso_i};
      tgl_sync_q <= {tgl_sync_q[0], ltgl_q};
      busy_sync_q <= {busy_sync_q[0], lbusy_q};
      ss_prev_q <= ss_sync_q[1];
      tgl_prev_q <= tgl_sync_q[1];
      if (ss_sync_q[1] || slave_done) begin
        xfer_open_q <= 1'b0;
      end else if (busy_sync_q[1] || (ss_prev_q && !cfg.clock_phase)) begin
        xfer_open_q <= 1'b1;
      end
    end
  end

  // slave link logic: deselect is an async clear, so edges are ignored
  assign link_rst_n = rstn & ~ss_n_i;
  always_ff @(negedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lcnt_q <= '0;
      lsh_q <= 7'h00;
      lbusy_q <= 1'b0;
    end else begin
      lcnt_q <= lcnt_q + 1'b1;
      lsh_q <= {lsh_q[5:0], mosi_i};
      lbusy_q <= (lcnt_q != 3'h7);
    end
  end

  // word and toggle outlive the select so the other domain can fetch them
  always_ff @(negedge link_sck or negedge rstn) begin
    if (!rstn) begin
      lword_q <= `SIRQ_DATA_RST;
      ltgl_q <= 1'b0;
    end else if (!ss_n_i && lcnt_q == 3'h7) begin
      lword_q <= {lsh_q, mosi_i};
      ltgl_q <= ~ltgl_q;
    end
  end

  // slave output changes on the leading edge; tx_shadow_q is quiet while the link is busy
  always_ff @(posedge link_sck or negedge rstn) begin
    if (!rstn) begin
      miso_o <= 1'b0;
    end else if (!ss_n_i) begin
      miso_o <= tx_shadow_q[3'h7 - lcnt_q];
    end
  end

  assign slave_done = (tgl_sync_q[1] ^ tgl_prev_q) & cfg.module_enable & ~cfg.master_select;

  // master engine: serial clock divided from mclk, stalls in stop mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mst_q <= SIRQ_M_IDLE;
      div_q <= '0;
      mbit_q <= '0;
      msh_q <= `SIRQ_DATA_RST;
      mcap_q <= 1'b0;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
    end else if (!cfg.module_enable || !cfg.master_select) begin
      mst_q <= SIRQ_M_IDLE;
      div_q <= '0;
      mbit_q <= '0;
      sck_o <= 1'b0;
    end else if (!stop_mode) begin
      case (mst_q)
        SIRQ_M_IDLE: begin
          if (!flags_q.tx_empty_flag) begin
            msh_q <= tx_hold_q;
            mosi_o <= tx_hold_q[7];
            mst_q <= SIRQ_M_RUN;
            div_q <= '0;
            mbit_q <= '0;
          end
        end
        SIRQ_M_RUN: begin
          if (div_q == `SIRQ_DIV_W'(`SIRQ_HALF_CYC - 1)) begin
            div_q <= '0;
            sck_o <= ~sck_o;
            if (!sck_o) begin
              mcap_q <= miso_sync_q[1];
            end else begin
              msh_q <= {msh_q[6:0], mcap_q};
              mosi_o <= msh_q[6];
              mbit_q <= mbit_q + 1'b1;
              if (mbit_q == 3'h7) begin
                mst_q <= SIRQ_M_DONE;
              end
            end
          end else begin
            div_q <= div_q + 1'b1;
          end
        end
        SIRQ_M_DONE: begin
          mst_q <= SIRQ_M_IDLE;
        end
        default: begin
          mst_q <= SIRQ_M_IDLE;
        end
      endcase
    end
  end

  assign mst_done = (mst_q == SIRQ_M_DONE) & ~stop_mode;
  assign byte_done = (mst_done | slave_done) & ~stop_mode;
  assign byte_in = cfg.master_select ? msh_q : lword_q;
  // the transmit byte goes into the shifter: master start, or slave while idle
  assign tx_move = cfg.module_enable & ~stop_mode & ~flags_q.tx_empty_flag &
                   (cfg.master_select ? (mst_q == SIRQ_M_IDLE) : ~busy_sync_q[1]);
  assign fault_now = cfg.fault_detect_enable & cfg.module_enable &
                     (cfg.master_select ? ss_low :
                      (ss_sync_q[1] & ~ss_prev_q & xfer_open_q));

  // transmit data register and slave shadow
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_hold_q <= `SIRQ_DATA_RST;
      tx_shadow_q <= `SIRQ_DATA_RST;
    end else begin
      if (data_wr) begin
        tx_hold_q <= acc.wdata;
      end
      if (tx_move && !cfg.master_select) begin
        tx_shadow_q <= tx_hold_q;
      end
    end
  end

  // transmit empty: set on move or disable, cleared by a write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q.tx_empty_flag <= `SIRQ_TX_RST;
    end else if (tx_move || !cfg.module_enable) begin
      flags_q.tx_empty_flag <= 1'b1;
    end else if (data_wr && !protect) begin
      flags_q.tx_empty_flag <= 1'b0;
    end
  end

  // first step of the two-step clears; an arm survives the break
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arm_rx_q <= 1'b0;
      arm_ovr_q <= 1'b0;
      arm_mf_q <= 1'b0;
    end else begin
      if (stat_rd && !protect) begin
        arm_rx_q <= flags_q.rx_full_flag;
        arm_ovr_q <= flags_q.overrun_flag;
        arm_mf_q <= flags_q.mode_fault_flag;
      end else if (data_rd && !protect) begin
        arm_rx_q <= 1'b0;
        arm_ovr_q <= 1'b0;
      end else if (ctrl_wr && !protect) begin
        arm_mf_q <= 1'b0;
      end
    end
  end

  // receive full and overrun; a newly landed byte beats the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q.rx_full_flag <= `SIRQ_FLAG_RST;
      flags_q.overrun_flag <= `SIRQ_FLAG_RST;
      rx_data_q <= `SIRQ_DATA_RST;
    end else begin
      if (byte_done && (flags_q.rx_full_flag || flags_q.overrun_flag)) begin
        flags_q.overrun_flag <= 1'b1;
      end else if (data_rd && !protect && arm_ovr_q) begin
        flags_q.overrun_flag <= 1'b0;
      end
      if (byte_done && !flags_q.rx_full_flag && !flags_q.overrun_flag) begin
        flags_q.rx_full_flag <= 1'b1;
        rx_data_q <= byte_in;
      end else if (data_rd && !protect && arm_rx_q) begin
        flags_q.rx_full_flag <= 1'b0;
      end
    end
  end

  // mode fault: only with detection on; a present condition blocks the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q.mode_fault_flag <= `SIRQ_FLAG_RST;
    end else if (fault_now) begin
      flags_q.mode_fault_flag <= 1'b1;
    end else if (ctrl_wr && !protect && arm_mf_q) begin
      flags_q.mode_fault_flag <= 1'b0;
    end
  end

  // level requests, registered one cycle behind their flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_tx_q <= 1'b0;
      irq_rx_q <= 1'b0;
      irq_err_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_tx_q <= flags_q.tx_empty_flag & cfg.tx_irq_enable & cfg.module_enable;
      irq_rx_q <= flags_q.rx_full_flag & cfg.rx_irq_enable;
      irq_err_q <= (flags_q.overrun_flag | flags_q.mode_fault_flag) &
                   cfg.error_irq_enable;
      wake_q <= wait_mode & ((flags_q.tx_empty_flag & cfg.tx_irq_enable & cfg.module_enable) |
                (flags_q.rx_full_flag & cfg.rx_irq_enable) |
                ((flags_q.overrun_flag | flags_q.mode_fault_flag) &
                 cfg.error_irq_enable));
    end
  end

  // pin ownership; enables are active low, high hands the pin back
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins_owned_q <= 1'b0;
      ss_gpio_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      mosi_oe_n_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else begin
      pins_owned_q <= cfg.module_enable;
      ss_gpio_q <= ~cfg.module_enable |
                   (cfg.master_select & ~cfg.fault_detect_enable);
      sck_oe_n_q <= ~(cfg.module_enable & cfg.master_select);
      mosi_oe_n_q <= ~(cfg.module_enable & cfg.master_select);
      miso_oe_n_q <= ~slave_sel;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_tx_irq;
    irq_tx_q |-> $past(flags_q.tx_empty_flag && cfg.tx_irq_enable && cfg.module_enable);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx request without cause");
  property p_rx_irq;
    (flags_q.rx_full_flag && cfg.rx_irq_enable) |=> irq_rx_q;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request missing");
  property p_err_irq;
    ((flags_q.overrun_flag || flags_q.mode_fault_flag) && cfg.error_irq_enable) |=> irq_err_q;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error request missing");
  property p_tx_clear;
    (data_wr && !protect && !tx_move && cfg.module_enable) |=> !flags_q.tx_empty_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("write did not clear empty");
  property p_rx_set;
    byte_done |=> (flags_q.rx_full_flag || flags_q.overrun_flag);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("byte lost without flag");
  property p_no_fault;
    (!cfg.fault_detect_enable && !flags_q.mode_fault_flag) |=> !$rose(flags_q.mode_fault_flag);
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault set while disabled");
  property p_protect;
    (protect && $past(protect)) |-> !$fell(flags_q.rx_full_flag) && !$fell(flags_q.mode_fault_flag);
  endproperty
  a_protect: assert property (p_protect) else $error("flag cleared in protected break");
  property p_miso_oe;
    !miso_oe_n_q |-> $past(cfg.module_enable && !cfg.master_select && ss_low);
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("data out driven unselected");
  property p_keep;
    (byte_done && flags_q.rx_full_flag) |=> $stable(rx_data_q);
  endproperty
  a_keep: assert property (p_keep) else $error("unread byte overwritten");
  property p_disabled_pins;
    !cfg.module_enable [*2] |-> sck_oe_n_q && mosi_oe_n_q && miso_oe_n_q && ss_gpio_q;
  endproperty
  a_disabled_pins: assert property (p_disabled_pins) else $error("pins held while off");
  property p_eight;
    (mst_q == SIRQ_M_IDLE && tx_move && cfg.master_select && !stop_mode)
      ##1 (!stop_mode && cfg.module_enable) [*8] |-> mst_q == SIRQ_M_RUN;
  endproperty
  a_eight: assert property (p_eight) else $error("master byte ended early");

  c_master_byte: cover property (mst_q == SIRQ_M_DONE);
  c_slave_byte: cover property (slave_done);
  c_overrun: cover property ($rose(flags_q.overrun_flag));
  c_fault: cover property ($rose(flags_q.mode_fault_flag));
endmodule
`default_nettype wire

// ---- verification/sirq_far.sv ----
// remote peer: master for slave-mode frames, slave for master-mode bytes
`timescale 1ns/1ps
`default_nettype none
module sirq_far (
  // device link outputs
  input wire logic sck_o,
  input wire logic mosi_o,
  input wire logic miso_o,
  // peer drives
  output logic link_sck,
  output logic ss_n,
  output logic mosi,
  output logic miso
);
  logic [7:0] sh;
  logic [7:0] nxt;
  logic [7:0] got;
  logic [7:0] sgot;
  logic [2:0] cnt;
  initial begin
    link_sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    sh = 8'h00;
    nxt = 8'h00;
    cnt = 3'h0;
  end
  // msb first; next byte is presented right after the eighth fall
  assign miso = sh[7];
  always @(posedge sck_o) got <= {got[6:0], mosi_o};
  // slave data is taken on the fall, half a period after the device launched it
  always @(negedge link_sck) sgot <= {sgot[6:0], miso_o};
  always @(negedge sck_o) begin
    cnt <= cnt + 3'h1;
    sh <= (cnt == 3'h7) ? nxt : {sh[6:0], 1'b0};
  end
  task automatic load(input logic [7:0] v);
    nxt = v;
    sh = v;
  endtask
  task automatic sel(input logic v);
    ss_n = v;
  endtask
  // link clock runs only inside the frame; data leaves on rise
  task automatic frame(input logic [7:0] v, input int n);
    #32;
    for (int i = 0; i < n; i++) begin
      link_sck = 1'b1;
      mosi = v[7-i];
      #32;
      link_sck = 1'b0;
      #32;
    end
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the serial flag, request and pin-ownership block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sirq_pkg::*;
  localparam logic [3:0] ST = 4'h8;
  localparam logic [3:0] RD = 4'h4;
  localparam logic [3:0] WR = 4'h2;
  localparam logic [3:0] CW = 4'h1;
  logic mclk, rstn, wait_mode, stop_mode, break_active, break_clear_enable;
  sirq_cfg_t cfg;
  sirq_acc_t acc;
  sirq_flags_t flags_q;
  logic [7:0] rx_data_q;
  logic irq_tx_q, irq_rx_q, irq_err_q, wake_q, pins_owned_q, ss_gpio_q;
  logic link_sck, ss_n, mosi, miso, mosi_o, miso_o, sck_o;
  logic mosi_oe_n_q, miso_oe_n_q, sck_oe_n_q;
  int fails;
  int checked;
  sirq_top u_sirq_top (.mclk(mclk), .rstn(rstn), .cfg(cfg), .acc(acc), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .break_active(break_active), .break_clear_enable(break_clear_enable),
    .rx_data_q(rx_data_q), .flags_q(flags_q), .irq_tx_q(irq_tx_q), .irq_rx_q(irq_rx_q),
    .irq_err_q(irq_err_q), .wake_q(wake_q), .pins_owned_q(pins_owned_q), .ss_gpio_q(ss_gpio_q),
    .link_sck(link_sck), .ss_n_i(ss_n), .mosi_i(mosi), .miso_i(miso), .mosi_o(mosi_o),
    .mosi_oe_n_q(mosi_oe_n_q), .miso_o(miso_o), .miso_oe_n_q(miso_oe_n_q), .sck_o(sck_o),
    .sck_oe_n_q(sck_oe_n_q));
  sirq_far u_sirq_far (.sck_o(sck_o), .mosi_o(mosi_o), .miso_o(miso_o), .link_sck(link_sck),
    .ss_n(ss_n), .mosi(mosi), .miso(miso));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(input logic [3:0] k, input logic [7:0] d);
    acc = {k, d};
    tick(1);
    acc = '0;
    tick(1);
  endtask
  task automatic wait_rx;
    int n;
    n = 0;
    while (flags_q.rx_full_flag !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk({7'h0, flags_q.rx_full_flag}, 8'h01, "receive full");
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] r);
    u_sirq_far.load(r);
    pulse(WR, d);
    wait_rx();
    tick(3);
  endtask
  task automatic clr_rx;
    pulse(ST, 8'h00);
    pulse(RD, 8'h00);
    tick(3);
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // under a thousand cycles expected; cut off well beyond that
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    fails = 0;
    checked = 0;
    rstn = 1'b0;
    cfg = '0;
    acc = '0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    break_active = 1'b0;
    break_clear_enable = 1'b0;
    tick(5);
    rstn = 1'b1;
    tick(3);
    chk({4'h0, flags_q}, 8'h08, "reset flags");
    chk({5'h0, mosi_oe_n_q, miso_oe_n_q, sck_oe_n_q}, 8'h07, "reset enables");
    cfg.tx_irq_enable = 1'b1;
    tick(3);
    chk({7'h0, irq_tx_q}, 8'h00, "tx request while disabled");
    cfg.module_enable = 1'b1;
    cfg.master_select = 1'b1;
    u_sirq_far.sel(1'b0);
    tick(3);
    chk({7'h0, irq_tx_q}, 8'h01, "tx request");
    chk({4'h0, pins_owned_q, mosi_oe_n_q, sck_oe_n_q, ss_gpio_q}, 8'h09, "master pins");
    chk({4'h0, flags_q}, 8'h08, "no fault without detect");
    u_sirq_far.sel(1'b1);
    xfer(8'ha5, 8'h3c);
    chk(rx_data_q, 8'h3c, "master capture");
    chk(u_sirq_far.got, 8'ha5, "master send");
    cfg.rx_irq_enable = 1'b1;
    cfg.module_enable = 1'b0;
    tick(3);
    chk({6'h0, irq_rx_q, irq_tx_q}, 8'h02, "rx request while disabled");
    chk({4'h0, pins_owned_q, mosi_oe_n_q, miso_oe_n_q, sck_oe_n_q}, 8'h07, "released pins");
    cfg.module_enable = 1'b1;
    clr_rx();
    chk({7'h0, flags_q.rx_full_flag}, 8'h00, "full cleared");
    // second write lands while the first byte shifts, then overruns
    u_sirq_far.load(8'h11);
    u_sirq_far.nxt = 8'h22;
    pulse(WR, 8'h01);
    tick(6);
    pulse(WR, 8'h02);
    tick(5);
    chk({7'h0, flags_q.tx_empty_flag}, 8'h00, "write clears empty");
    wait_rx();
    tick(4);
    chk({7'h0, flags_q.tx_empty_flag}, 8'h01, "move sets empty");
    tick(80);
    chk({4'h0, flags_q}, 8'h0e, "overrun flags");
    chk(rx_data_q, 8'h11, "unread byte kept");
    cfg.error_irq_enable = 1'b1;
    tick(3);
    chk({7'h0, irq_err_q}, 8'h01, "error request");
    clr_rx();
    tick(2);
    chk({3'h0, irq_err_q, flags_q}, 8'h08, "overrun cleared");
    // stop freezes a byte in mid-flight
    u_sirq_far.load(8'h77);
    pulse(WR, 8'h44);
    tick(20);
    stop_mode = 1'b1;
    tick(150);
    chk({4'h0, flags_q}, 8'h08, "frozen in stop");
    stop_mode = 1'b0;
    wait_rx();
    chk(rx_data_q, 8'h77, "resumed byte");
    wait_mode = 1'b1;
    tick(3);
    chk({7'h0, wake_q}, 8'h01, "wake");
    clr_rx();
    chk({7'h0, flags_q.rx_full_flag}, 8'h01, "access refused in wait");
    wait_mode = 1'b0;
    pulse(ST, 8'h00);
    break_active = 1'b1;
    clr_rx();
    chk({7'h0, flags_q.rx_full_flag}, 8'h01, "protected in break");
    break_active = 1'b0;
    pulse(RD, 8'h00);
    tick(3);
    chk({7'h0, flags_q.rx_full_flag}, 8'h00, "armed clear after break");
    xfer(8'h00, 8'h66);
    break_clear_enable = 1'b1;
    break_active = 1'b1;
    clr_rx();
    chk({7'h0, flags_q.rx_full_flag}, 8'h00, "clear in break");
    break_active = 1'b0;
    tick(3);
    chk({7'h0, flags_q.rx_full_flag}, 8'h00, "stays clear");
    break_clear_enable = 1'b0;
    cfg.fault_detect_enable = 1'b1;
    tick(3);
    chk({7'h0, ss_gpio_q}, 8'h00, "master select is input");
    u_sirq_far.sel(1'b0);
    tick(4);
    chk({7'h0, flags_q.mode_fault_flag}, 8'h01, "master fault");
    u_sirq_far.sel(1'b1);
    tick(3);
    pulse(ST, 8'h00);
    pulse(CW, 8'h00);
    tick(3);
    chk({7'h0, flags_q.mode_fault_flag}, 8'h00, "fault cleared");
    // slave mode with phase 1 framing
    cfg.master_select = 1'b0;
    cfg.clock_phase = 1'b1;
    tick(3);
    chk({6'h0, ss_gpio_q, miso_oe_n_q}, 8'h01, "deselected slave");
    u_sirq_far.frame(8'hc3, 8);
    tick(8);
    chk({7'h0, flags_q.rx_full_flag}, 8'h00, "clocks ignored");
    u_sirq_far.sel(1'b0);
    tick(3);
    chk({7'h0, miso_oe_n_q}, 8'h00, "selected slave drives");
    u_sirq_far.frame(8'h5a, 4);
    u_sirq_far.sel(1'b1);
    tick(6);
    chk({5'h0, irq_err_q, flags_q.rx_full_flag, flags_q.mode_fault_flag}, 8'h05, "abort");
    pulse(ST, 8'h00);
    pulse(CW, 8'h00);
    cfg.fault_detect_enable = 1'b0;
    pulse(WR, 8'h96);
    u_sirq_far.sel(1'b0);
    u_sirq_far.frame(8'h5a, 8);
    wait_rx();
    u_sirq_far.sel(1'b1);
    chk(rx_data_q, 8'h5a, "slave byte");
    chk(u_sirq_far.sgot, 8'h96, "slave send");
    // phase 0: a whole byte then deselect is clean, select without clocks faults
    cfg.clock_phase = 1'b0;
    cfg.fault_detect_enable = 1'b1;
    clr_rx();
    u_sirq_far.sel(1'b0);
    tick(3);
    u_sirq_far.frame(8'h81, 8);
    u_sirq_far.sel(1'b1);
    tick(6);
    chk({6'h0, flags_q.rx_full_flag, flags_q.mode_fault_flag}, 8'h02, "phase 0 byte");
    chk(rx_data_q, 8'h81, "phase 0 data");
    u_sirq_far.sel(1'b0);
    tick(6);
    u_sirq_far.sel(1'b1);
    tick(6);
    chk({7'h0, flags_q.mode_fault_flag}, 8'h01, "phase 0 deselect");
    // reset while a master byte is frozen in stop
    cfg.fault_detect_enable = 1'b0;
    cfg.master_select = 1'b1;
    u_sirq_far.load(8'h55);
    pulse(WR, 8'h33);
    tick(20);
    stop_mode = 1'b1;
    tick(5);
    rstn = 1'b0;
    tick(3);
    stop_mode = 1'b0;
    rstn = 1'b1;
    tick(3);
    chk({3'h0, sck_o, flags_q}, 8'h08, "reset out of stop");
    chk(rx_data_q, 8'h00, "receive data reset");
    test_done();
  end
endmodule
`default_nettype wire
